// [src/qa_watchdog_pkg.sv]
/*
 * Watchdog constants: register map, fields, resets and timing.
 * Assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock.
 */
package qa_watchdog_pkg;

    // Register byte offsets
    localparam logic [7:0] question_low_reg_off   = 8'h00;
    localparam logic [7:0] question_high_reg_off  = 8'h04;
    localparam logic [7:0] answer_byte_reg_off    = 8'h08;
    localparam logic [7:0] response_delay_reg_off = 8'h0c;
    localparam logic [7:0] control_reg_off        = 8'h10;
    localparam logic [7:0] status_reg_off         = 8'h14;

    // Reset values and tally limits
    localparam logic [2:0] fault_tally_init = 3'h6;
    localparam logic [1:0] byte_index_init  = 2'h3;
    localparam logic [2:0] tally_max        = 3'h7;
    localparam logic [2:0] alarm_limit      = 3'h4;
    localparam logic [2:0] abort_clear_lim  = 3'h5;

    // Control register field positions
    localparam int ctrl_reset_enable_bit = 0;
    localparam int ctrl_power_latch_bit  = 1;

    // Timebase: 64 kHz watchdog tick from 125 MHz clock
    localparam int clk_freq_hz      = 125_000_000;
    localparam int timebase_freq_hz = 64_000;
    localparam int timebase_div     = clk_freq_hz / timebase_freq_hz;

    // AXI response codes
    localparam logic [1:0] axi_okay   = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;

endpackage : qa_watchdog_pkg

// [src/qa_watchdog.sv]
/*
 * Question-and-answer watchdog with AXI4-Lite register access.
 * Assumes answer bytes arrive 3 down to 0 and the
 * undervoltage reset comes from a pin, synchronised here.
 */
// The address map and the AXI4-Lite slave port were chosen for this implementation.
// Functional notes
// R1: Four-bit question readable in low question register
// R2: Controller writes answer bytes three down to zero
// R3: Answer byte zero or delay write restarts cycle
// R4: Cycle is programmable wait then fixed window
// R5: Correct timely answer, nonzero delay: decrement faults
// R6: Wrong, late, early, or zero delay: increment faults
// R7: Only byte zero write time is judged
// R8: Same question repeats until answered correctly
// R9: Three-bit fault tally starts at six
// R10: Fault tally above four raises alarm
// R11: Overflow issues system reset when enabled
// R12: System reset also drives alarm pin low
// R13: Reset tally stops resets at seven
// R14: Overflows bump abort tally; seven plus error aborts; here only an overflow at abort tally seven aborts
// R15: Abort tally clears only below five or undervoltage
// R16: Result and next question readable after byte zero
// R17: Question counter advances only on correct answer
// R18: Chain steps when counter wraps after correct answer
// R19: Delay write or window expiry keeps question state
// R20: Counter and chain cleared during undervoltage reset
// R21: Chain feedback: upper XOR plus all-zero escape
// R22: Question bits mix chain and counter bits
// R23: Byte index counts down from three, last runs
// R24: Enabled overflow drives system reset, tally limited
// R25: Abort during power-latch shuts relay and regulators
// R26: Chain is four-bit shift register, shifting up
// R27: Window length is parameter in timebase ticks
`timescale 1ns/1ns
`default_nettype none

module qa_watchdog
    import qa_watchdog_pkg::*;
#(
    parameter int WINDOW_TICKS = 64,      // Fixed window length, ticks
    parameter int DELAY_WIDTH  = 8        // Response delay field width
) (
    input  wire logic        i_ref_clk,     // 125 MHz system clock
    input  wire logic        i_rst,         // Synchronous reset, active high
    input  wire logic        i_uv_rst_pin,  // Undervoltage reset pin, async
    // AXI4-Lite slave
    input  wire logic [7:0]  i_awaddr,      // Write address
    input  wire logic        i_awvalid,     // Write address valid
    output logic             o_awready,     // Write address ready
    input  wire logic [31:0] i_wdata,       // Write data
    input  wire logic [3:0]  i_wstrb,       // Write byte strobes
    input  wire logic        i_wvalid,      // Write data valid
    output logic             o_wready,      // Write data ready
    output logic [1:0]       o_bresp,       // Write response
    output logic             o_bvalid,      // Write response valid
    input  wire logic        i_bready,      // Write response ready
    input  wire logic [7:0]  i_araddr,      // Read address
    input  wire logic        i_arvalid,     // Read address valid
    output logic             o_arready,     // Read address ready
    output logic [31:0]      o_rdata,       // Read data
    output logic [1:0]       o_rresp,       // Read response
    output logic             o_rvalid,      // Read data valid
    input  wire logic        i_rready,      // Read data ready
    // Pins
    output logic             o_alarm_output_pin_n, // Alarm, active low
    output logic             o_system_reset,       // Watchdog reset pulse
    output logic             o_afterrun_abort_signal, // Abort after-run
    output logic             o_shutdown_relay_reg  // Relay+regulator off
);

    if (WINDOW_TICKS < 1 || WINDOW_TICKS > 65535) begin : g_bad_win
        $error("bad WINDOW_TICKS");
    end
    if (DELAY_WIDTH < 1 || DELAY_WIDTH > 16) begin : g_bad_delay
        $error("bad DELAY_WIDTH");
    end

    localparam logic [15:0] win_last = 16'(WINDOW_TICKS - 1);
    localparam logic [15:0] div_last = 16'(timebase_div - 1);

    typedef enum logic [1:0] {
        st_wait   = 2'b01,
        st_window = 2'b10
    } phase_e;

    typedef struct packed {
        logic                   uv_s1;
        logic                   uv_s2;
        logic [15:0]            div_cnt;
        phase_e                 phase;
        logic [15:0]            tick_cnt;
        logic [DELAY_WIDTH-1:0] delay;
        logic [3:0]             count;      // Question counter
        logic [3:0]             chain;      // Feedback chain
        logic [1:0]             byte_idx;
        logic                   resp_err;
        logic                   last_err;   // Result of last answer, bytes and timing
        logic [2:0]             fault_tally;
        logic [2:0]             reset_event_tally;
        logic [2:0]             afterrun_abort_tally;
        logic                   abort;
        logic                   reset_enable_cfg;
        logic                   power_latch;
        logic                   sys_rst;
        logic                   rst_flag;   // Sticky, cleared on read
        logic                   aw_hold;
        logic [7:0]             aw_addr;
        logic                   w_hold;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_s;

    state_s q;
    state_s d;

    ////////////////////////////////////////////////////////////////////////
    // Combinational helpers

    logic [3:0] question_word;
    logic [7:0] expected;
    logic       alarm_internal_signal;

    // Question from chain and counter
    always_comb begin
        question_word[0] = q.chain[1] ^ q.count[1]; // R22
        question_word[1] = q.chain[3] ^ q.count[3]; // R22
        question_word[2] = q.chain[0] ^ q.count[0]; // R22
        question_word[3] = q.chain[2] ^ q.count[2]; // R22
    end

    // Expected answer byte for the current byte index
    always_comb begin
        expected[7] = question_word[2] ^ q.byte_idx[0];
        expected[6] = question_word[0] ^ q.byte_idx[0];
        expected[5] = question_word[3] ^ q.byte_idx[0];
        expected[4] = question_word[1] ^ q.byte_idx[0];
        expected[3] = question_word[2] ^ question_word[0]
                    ^ question_word[3] ^ q.byte_idx[1];
        expected[2] = question_word[0] ^ question_word[3]
                    ^ question_word[1] ^ q.byte_idx[1];
        expected[1] = question_word[2] ^ question_word[0]
                    ^ question_word[1] ^ q.byte_idx[1];
        expected[0] = q.byte_idx[1] ^ question_word[3] ^ question_word[0];
    end

    assign alarm_internal_signal = (q.fault_tally > alarm_limit); // R10

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic       uv;
        logic       tick;
        logic       wr_go;
        logic       rd_go;
        logic       ans_wr;
        logic       delay_wr;
        logic       final_byte;
        logic       byte_bad;
        logic       in_time;
        logic       error;
        logic       overflow;
        logic       win_end;
        uv         = 1'b0;
        tick       = 1'b0;
        wr_go      = 1'b0;
        rd_go      = 1'b0;
        ans_wr     = 1'b0;
        delay_wr   = 1'b0;
        final_byte = 1'b0;
        byte_bad   = 1'b0;
        in_time    = 1'b0;
        error      = 1'b0;
        overflow   = 1'b0;
        win_end    = 1'b0;
        d = q;

        // Undervoltage reset pin through two flops
        d.uv_s1 = i_uv_rst_pin;
        d.uv_s2 = q.uv_s1;
        uv      = q.uv_s2;

        // 64 kHz timebase enable
        tick = (q.div_cnt == div_last);
        d.div_cnt = tick ? 16'h0000 : q.div_cnt + 16'h0001;

        d.sys_rst = 1'b0;

        // AXI write channel capture, either order
        if (i_awvalid && !q.aw_hold) begin
            d.aw_hold = 1'b1;
            d.aw_addr = i_awaddr;
        end
        if (i_wvalid && !q.w_hold) begin
            d.w_hold = 1'b1;
            d.w_data = i_wdata;
            d.w_strb = i_wstrb;
        end
        wr_go = q.aw_hold && q.w_hold && !q.bvalid;
        if (q.bvalid && i_bready)
            d.bvalid = 1'b0;

        if (wr_go) begin
            d.aw_hold = 1'b0;
            d.w_hold  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = axi_okay;
            unique case (q.aw_addr)
                answer_byte_reg_off:    ans_wr = q.w_strb[0];
                response_delay_reg_off: delay_wr = 1'b1;
                control_reg_off: begin
                    if (q.w_strb[0]) begin
                        d.reset_enable_cfg = q.w_data[ctrl_reset_enable_bit];
                        d.power_latch      = q.w_data[ctrl_power_latch_bit];
                    end
                end
                question_low_reg_off, question_high_reg_off,
                status_reg_off: d.bresp = axi_okay;
                default: d.bresp = axi_slverr;
            endcase
        end
        if (delay_wr)
            d.delay = q.w_data[DELAY_WIDTH-1:0];

        // AXI read channel: one read at a time
        rd_go = i_arvalid && !q.rvalid;
        if (q.rvalid && i_rready)
            d.rvalid = 1'b0;

        // R2 R23: answer byte comparison, byte index steps down
        if (ans_wr) begin
            byte_bad   = (q.w_data[7:0] != expected);
            d.resp_err = q.resp_err | byte_bad;
            d.byte_idx = q.byte_idx - 2'h1; // R23
            final_byte = (q.byte_idx == 2'h0); // R23
        end

        // R4 R27: wait phase then fixed window in timebase ticks
        if (tick) begin
            unique case (q.phase)
                st_wait: begin
                    if (q.tick_cnt >= 16'(q.delay)) begin
                        d.phase    = st_window;
                        d.tick_cnt = 16'h0000;
                    end else
                        d.tick_cnt = q.tick_cnt + 16'h0001;
                end
                st_window: begin
                    if (q.tick_cnt == win_last)
                        win_end = 1'b1; // R4
                    else
                        d.tick_cnt = q.tick_cnt + 16'h0001;
                end
            endcase
        end

        // R7: only the final byte's arrival is timed
        in_time = (q.phase == st_window); // R7

        // Sequencer run from final byte
        if (final_byte) begin
            error = q.resp_err || byte_bad || !in_time
                 || (q.delay == '0); // R6
            d.last_err = error; // R16
            if (!error) begin
                d.count = q.count + 4'h1; // R17 R8
                if (q.count == 4'hf) // R18
                    d.chain = {q.chain[2:0],
                        (q.chain[3] ^ q.chain[2]) ^ ~|q.chain}; // R21 R26
                if (q.fault_tally != 3'h0)
                    d.fault_tally = q.fault_tally - 3'h1; // R5
            end else if (q.fault_tally == tally_max) begin
                overflow      = 1'b1;
                d.fault_tally = fault_tally_init; // R9
            end else
                d.fault_tally = q.fault_tally + 3'h1; // R6
        end

        // R3 R19: restart cycle; delay write and expiry keep question
        if (final_byte || delay_wr || win_end) begin
            d.phase    = st_wait; // R3
            d.tick_cnt = 16'h0000;
            d.byte_idx = byte_index_init;
            d.resp_err = 1'b0;
        end

        // R11 R13 R24: overflow reset, limited by reset tally
        if (overflow && q.reset_enable_cfg
            && q.reset_event_tally != tally_max) begin
            d.sys_rst           = 1'b1; // R11 R24
            d.rst_flag          = 1'b1;
            d.reset_event_tally = q.reset_event_tally + 3'h1; // R13
        end

        // R14 R15: after-run abort tally and abort signal
        if (d.fault_tally < abort_clear_lim) begin
            d.afterrun_abort_tally = 3'h0; // R15
            d.abort                = 1'b0;
        end else if (overflow) begin
            if (q.afterrun_abort_tally == tally_max)
                d.abort = 1'b1; // R14
            else
                d.afterrun_abort_tally = q.afterrun_abort_tally + 3'h1;
        end

        // Register reads; status flag clear loses to a new set
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp  = axi_okay;
            d.rdata  = 32'h0000_0000;
            unique case (i_araddr)
                question_low_reg_off:
                    d.rdata[3:0] = question_word; // R1 R16
                question_high_reg_off: begin
                    d.rdata[0]   = q.last_err; // R16
                    d.rdata[3:1] = q.fault_tally;
                end
                response_delay_reg_off:
                    d.rdata[DELAY_WIDTH-1:0] = q.delay;
                control_reg_off: begin
                    d.rdata[ctrl_reset_enable_bit] = q.reset_enable_cfg;
                    d.rdata[ctrl_power_latch_bit]  = q.power_latch;
                end
                status_reg_off: begin
                    d.rdata[2:0]  = q.reset_event_tally;
                    d.rdata[5:3]  = q.afterrun_abort_tally;
                    d.rdata[6]    = q.abort;
                    d.rdata[7]    = q.rst_flag;
                    d.rdata[9:8]  = q.byte_idx;
                    d.rdata[10]   = alarm_internal_signal;
                    d.rst_flag    = d.sys_rst;
                end
                answer_byte_reg_off: d.rdata = 32'h0000_0000;
                default: d.rresp = axi_slverr;
            endcase
        end

        // R20 and undervoltage clears of reset and abort tallies and abort; fault tally back to six
        if (uv) begin
            d.count                = 4'h0; // R20
            d.chain                = 4'h0; // R20
            d.fault_tally          = fault_tally_init; // R9
            d.reset_event_tally    = 3'h0;
            d.afterrun_abort_tally = 3'h0; // R15
            d.abort                = 1'b0;
            d.sys_rst              = 1'b0;
            d.byte_idx             = byte_index_init;
            d.resp_err             = 1'b0;
            d.phase                = st_wait;
            d.tick_cnt             = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q                      <= '0;
            q.phase                <= st_wait;
            q.fault_tally          <= fault_tally_init; // R9
            q.byte_idx             <= byte_index_init;
            q.bresp                <= axi_okay;
            q.rresp                <= axi_okay;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Handshake readies: each channel accepts while its own slot is empty
    assign o_awready = !q.aw_hold;
    assign o_wready  = !q.w_hold;
    assign o_arready = !q.rvalid;
    assign o_bvalid  = q.bvalid;
    assign o_bresp   = q.bresp;
    assign o_rvalid  = q.rvalid;
    assign o_rdata   = q.rdata;
    assign o_rresp   = q.rresp;

    // Pin low while alarm is high or a reset is issued
    assign o_alarm_output_pin_n = !(alarm_internal_signal // R10
                                    || q.sys_rst); // R12
    assign o_system_reset          = q.sys_rst;
    assign o_afterrun_abort_signal = q.abort;
    // Shutdown only matters in power-latch
    assign o_shutdown_relay_reg = q.abort && q.power_latch; // R25

endmodule : qa_watchdog

`default_nettype wire

// [test/qa_watchdog_monitor.sv]
/*
 * Port checker for the watchdog, bound to each instance.
 * Assumes it sees only the top module's ports.
 */
`timescale 1ns/1ns
`default_nettype none

module qa_watchdog_monitor (
    input wire logic        i_ref_clk,               // Clock
    input wire logic        i_rst,                   // Reset
    input wire logic        i_awvalid,               // AW valid
    input wire logic        o_awready,               // AW ready
    input wire logic        i_wvalid,                // W valid
    input wire logic        o_wready,                // W ready
    input wire logic [1:0]  o_bresp,                 // B code
    input wire logic        o_bvalid,                // B valid
    input wire logic        i_bready,                // B ready
    input wire logic        i_arvalid,               // AR valid
    input wire logic        o_rvalid,                // R valid
    input wire logic [31:0] o_rdata,                 // R data
    input wire logic        i_rready,                // R ready
    input wire logic        o_alarm_output_pin_n,    // Alarm pin
    input wire logic        o_system_reset,          // Reset pulse
    input wire logic        o_afterrun_abort_signal, // Abort
    input wire logic        o_shutdown_relay_reg     // Shutdown
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////
    // Pins: tally starts at six, so the alarm is active out of reset
    a_reset_quiet: assert property ($fell(i_rst) |->
        !o_alarm_output_pin_n && !o_system_reset && !o_afterrun_abort_signal)
        else $error("outputs not idle after reset");
    a_reset_alarm: assert property (o_system_reset |->
        !o_alarm_output_pin_n) else $error("alarm high during reset");
    a_reset_single: assert property (o_system_reset |=>
        !o_system_reset) else $error("reset pulse too long");
    a_abort_alarm: assert property ($rose(o_afterrun_abort_signal) |->
        !o_alarm_output_pin_n) else $error("abort without alarm");
    a_shutdown_abort: assert property (o_shutdown_relay_reg |->
        o_afterrun_abort_signal) else $error("shutdown without abort");

    ////////////////////////////////////////////////////////////////////////
    // Register bus timing
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
        o_wready |-> ##2 o_bvalid) else $error("write response late");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write response dropped");
    a_read_answer: assert property (i_arvalid && !o_rvalid |=> o_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata)) else $error("read data dropped");

    // Main scenarios reached
    c_reset: cover property (o_system_reset);
    c_abort: cover property ($rose(o_afterrun_abort_signal));
    c_refused: cover property (o_bvalid && o_bresp == 2'h2);
endmodule : qa_watchdog_monitor

bind qa_watchdog qa_watchdog_monitor i_mon (.i_ref_clk, .i_rst, .i_awvalid,
    .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_arvalid, .o_rvalid, .o_rdata, .i_rready, .o_alarm_output_pin_n,
    .o_system_reset, .o_afterrun_abort_signal, .o_shutdown_relay_reg);

`default_nettype wire

// [test/qa_answer_model.sv]
/*
 * Answering controller: works out the four answer bytes for a question.
 * Assumes the bench sends byte 3 first and byte 0 last.
 */
`timescale 1ns/1ns
`default_nettype none

module qa_answer_model (
    input  wire logic [3:0]  i_question, // Question read back
    output logic      [31:0] o_answer    // Byte k in bits 8k+7..8k
);
    // Each byte mixes the question with its own byte index
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_answer[8*k +: 8] = {i_question[2] ^ k[0], i_question[0] ^ k[0],
                i_question[3] ^ k[0], i_question[1] ^ k[0],
                ^{i_question[2], i_question[0], i_question[3], k[1]},
                ^{i_question[0], i_question[3], i_question[1], k[1]},
                ^{i_question[2], i_question[0], i_question[1], k[1]},
                ^{k[1], i_question[3], i_question[0]}};
        end
    end
endmodule : qa_answer_model

`default_nettype wire

// [test/testbench.sv]
/*
 * Self-checking bench for the watchdog over its register bus.
 * Assumes a shortened window and the answering model beside it.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench
    import qa_watchdog_pkg::*;
;
    localparam int TIMELY = 2 * timebase_div + 200;
    typedef struct { string what; logic [33:0] exp, mask; } note_s;
    logic        i_ref_clk, i_rst, i_uv_rst_pin;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, seed, ans;
    logic [3:0]  i_wstrb, cnt, qm;
    logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic        o_alarm_output_pin_n, o_system_reset;
    logic        o_afterrun_abort_signal, o_shutdown_relay_reg;
    int          errors, total_checks, pulses, cycles;
    note_s       rq[$], bq[$], rn, bn;

    qa_watchdog #(.WINDOW_TICKS(2)) i_dut (.i_ref_clk, .i_rst, .i_uv_rst_pin,
        .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
        .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .o_alarm_output_pin_n, .o_system_reset, .o_afterrun_abort_signal,
        .o_shutdown_relay_reg);
    qa_answer_model i_model (.i_question(qm), .o_answer(ans));

    // Question model with the chain still at zero
    assign qm = {cnt[2], cnt[0], cnt[3], cnt[1]};

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [33:0] seen,
                         input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_done, w_done;
        bq.push_back('{"bresp", {er, 32'h0}, {2'h3, 32'h0}});
        @(posedge i_ref_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge i_ref_clk);
            if (i_awvalid && o_awready) begin
                aw_done = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_done = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do @(posedge i_ref_clk); while (!o_bvalid);
        i_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input string what,
                      input logic [33:0] exp, input logic [33:0] mask);
        rq.push_back('{what, exp & mask, mask});
        @(posedge i_ref_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_ref_clk); while (!o_arready);
        i_arvalid <= 1'b0;
        do @(posedge i_ref_clk); while (!o_rvalid);
        i_rready <= 1'b0;
    endtask : rd

    // Bytes 3..1 go early; only byte 0 timing is judged
    task automatic answer(input logic bad, input int gap);
        for (int k = 3; k > 0; k--) begin
            seed = lfsr(seed);
            wr(answer_byte_reg_off, {seed[31:8],ans[8*k+:8]}, axi_okay);
        end
        repeat (gap) @(posedge i_ref_clk);
        wr(answer_byte_reg_off, {seed[23:0],
            ans[7:0] ^ ({8{bad}} & (seed[7:0] | 8'h01))}, axi_okay);
    endtask : answer

    ////////////////////////////////////////////////////////////////////////
    // Checker, pulse count, hang guard
    always @(posedge i_ref_clk) begin
        cycles++;
        if (o_system_reset)
            pulses++;
        if (o_rvalid && i_rready) begin
            rn = rq.pop_front();
            check(rn.what, {o_rresp, o_rdata} & rn.mask, rn.exp);
        end
        if (o_bvalid && i_bready) begin
            bn = bq.pop_front();
            check(bn.what, {o_bresp, 32'h0} & bn.mask, bn.exp);
        end
        if (cycles == 40000) begin
            errors++;
            test_done;
        end
    end

    initial begin
        {i_uv_rst_pin, i_awaddr, i_araddr, i_wdata, cnt} = '0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        i_rst = 1'b1;
        i_wstrb = 4'hf;
        seed = 32'h0b24;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd(question_high_reg_off, "tally", 34'hc, 34'he);
        rd(question_low_reg_off, "question", 34'h0, 34'hf);
        rd(status_reg_off, "status", 34'h700, 34'h7ff);
        rd(answer_byte_reg_off, "answer reg", 34'h0, '1);
        rd(8'h18, "unmapped rd", {axi_slverr, 32'h0}, {2'h3, 32'h0});
        wr(8'h1c, 32'h1, axi_slverr);
        $display("test reset done");
        wr(response_delay_reg_off, 32'h0, axi_okay);
        for (int i = 0; i < 18; i++) begin
            if (i == 2)
                wr(control_reg_off, 32'h3, axi_okay);
            answer(i[0], 0);
            if (i == 1)
                check("resets off", 34'(pulses), 34'h0);
        end
        repeat (4) @(posedge i_ref_clk);
        check("resets", 34'(pulses), 34'h7);
        check("abort", {33'h0, o_afterrun_abort_signal}, 34'h1);
        check("shutdown", {33'h0, o_shutdown_relay_reg}, 34'h1);
        rd(status_reg_off, "tallies", 34'h7f, 34'h7f);
        rd(question_low_reg_off, "question", {30'h0, qm}, 34'hf);
        $display("test overflow done");
        wr(response_delay_reg_off, 32'h1, axi_okay);
        answer(1'b0, 0);
        rd(question_high_reg_off, "early", 34'hf, 34'hf);
        for (int i = 0; i < 3; i++) begin
            answer(1'b0, TIMELY);
            cnt++;
            rd(question_high_reg_off, "tally", 34'(12 - 2 * i), 34'he);
            rd(question_low_reg_off, "question", {30'h0, qm}, 34'hf);
        end
        check("alarm", {33'h0, o_alarm_output_pin_n}, 34'h1);
        check("abort off", {33'h0, o_afterrun_abort_signal}, 34'h0);
        rd(status_reg_off, "abort tally", 34'h0, 34'h78);
        $display("test timely done");
        @(posedge i_ref_clk);
        i_uv_rst_pin <= 1'b1;
        repeat (5) @(posedge i_ref_clk);
        i_uv_rst_pin <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        cnt = 4'h0;
        rd(question_high_reg_off, "tally", 34'hc, 34'he);
        rd(question_low_reg_off, "question", 34'h0, 34'hf);
        rd(status_reg_off, "tallies", 34'h0, 34'h3f);
        $display("test undervoltage done");
        test_done;
    end
endmodule : testbench

`default_nettype wire
